// >>> dv/iss_host.sv
/*
 * Host model that reaches the indexed registers one byte at a time.
 * Assumes the caller invokes acc from just after a clock edge.
 */
`timescale 1ns/1ps
module iss_host (
    // Clock
    input  wire logic       ref_clk,
    // Indexed register port
    output logic            bank_select = 1'b0,
    output logic [7:0]      reg_index   = 8'h00,
    output logic            reg_wr      = 1'b0,
    output logic            reg_rd      = 1'b0,
    output logic [7:0]      reg_wdata   = 8'h00
);
    // One access; released lines flip so stale values never look valid.
    task automatic acc(input logic w, input logic b, input logic [7:0] i, input logic [7:0] d);
        @(posedge ref_clk);
        bank_select <= b;
        reg_index   <= i;
        reg_wdata   <= d;
        reg_wr      <= w;
        reg_rd      <= !w;
        @(posedge ref_clk);
        reg_wr      <= 1'b0;
        reg_rd      <= 1'b0;
        reg_index   <= ~i;
        reg_wdata   <= ~d;
    endtask
endmodule

// >>> dv/iss_top_sva.sv
/*
 * Checker for the interrupt source select top module.
 * Assumes one clock, REF_CLK, and a synchronous active-high SRST.
 */
`timescale 1ns/1ps
module iss_top_sva (
    // Clock, reset and register port
    input wire logic       REF_CLK, SRST, BANK_SELECT, REG_RD,
    input wire logic [7:0] REG_RDATA,
    // Events and interrupt inputs
    input wire logic       THRESH_REACHED, FRAME_MAX, TRIG_START, TRIG_STOP, CLEAR_FLAGS,
    input wire logic       DMA_ENABLE, CLASSIC_SAMPLE_IRQ, CLASSIC_BURST_IRQ, DMA_IRQ, FIFO_IRQ,
    input wire logic [3:0] DIGITAL_INPUT, ADC_CHANNEL,
    // Outputs under watch
    input wire logic       THRESH_EVENT, THRESHOLD_COUNT_CLEAR, IRQ_REQUEST,
    input wire logic       SOURCE_A_FLAG, SOURCE_B_FLAG, ENHANCED_IRQ_SCHEME,
    input wire logic [3:0] STATUS_NIBBLE, FIFO_IRQ_INTERVAL, THRESHOLD_COUNTER_SOURCE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);

    // A classic request that DMA mode lets through, and a cycle with no request at all.
    sequence s_cls_dma;
        (CLASSIC_SAMPLE_IRQ || CLASSIC_BURST_IRQ) && DMA_ENABLE;
    endsequence
    sequence s_quiet;
        !(CLASSIC_SAMPLE_IRQ || CLASSIC_BURST_IRQ || DMA_IRQ || FIFO_IRQ);
    endsequence

    a_reset_zero: assert property (disable iff (1'b0) SRST |=> REG_RDATA == 8'h00
        && !SOURCE_A_FLAG && !SOURCE_B_FLAG && !ENHANCED_IRQ_SCHEME
        && THRESHOLD_COUNTER_SOURCE == 4'h0 && FIFO_IRQ_INTERVAL == 4'h0)
        else $error("state not cleared by reset");
    a_thresh_event: assert property (THRESH_REACHED |=> THRESH_EVENT)
        else $error("threshold event missing");
    a_sync_cause: assert property (THRESHOLD_COUNT_CLEAR |-> $past(TRIG_START))
        else $error("counter clear without trigger start");
    a_irq_dma: assert property (s_cls_dma |=> IRQ_REQUEST)
        else $error("classic request lost in DMA mode");
    a_irq_direct: assert property ((DMA_IRQ || FIFO_IRQ) |=> IRQ_REQUEST)
        else $error("DMA or FIFO request lost");
    a_irq_quiet: assert property (s_quiet |=> !IRQ_REQUEST)
        else $error("request without a source");
    a_status_map: assert property (STATUS_NIBBLE == $past(ADC_CHANNEL)
        || STATUS_NIBBLE == {2'b00, SOURCE_B_FLAG, SOURCE_A_FLAG})
        else $error("status nibble shows neither channel nor flags");
    a_flag_clear: assert property (CLEAR_FLAGS && !THRESH_REACHED && !FRAME_MAX
        && !TRIG_START && !TRIG_STOP && $stable(DIGITAL_INPUT)
        |=> !SOURCE_A_FLAG && !SOURCE_B_FLAG) else $error("flags survive a clear");
    a_bank_miss: assert property (REG_RD && !BANK_SELECT |=> REG_RDATA == 8'h00)
        else $error("read outside bank returned data");
endmodule

bind iss_top iss_top_sva i_iss_top_sva (.*);

// >>> dv/iss_top_tb_top.sv
/*
 * Self-checking bench for the interrupt source select block.
 * Assumes the design top, its checker bind and the host model are compiled first.
 */
`timescale 1ns/1ps
module iss_top_tb_top;
    logic REF_CLK = 0, SRST = 1, THRESH_REACHED = 0, FRAME_MAX = 0, SAMPLE_DONE = 0;
    logic BLOCK_DONE = 0, TRIG_START = 0, TRIG_STOP = 0, DMA_ENABLE = 0, DMA_IRQ = 0;
    logic CLASSIC_SAMPLE_IRQ = 0, CLASSIC_BURST_IRQ = 0, FIFO_IRQ = 0, CLEAR_FLAGS = 0;
    logic [3:0] DIGITAL_INPUT = 0, ADC_CHANNEL = 0, STATUS_NIBBLE, FIFO_IRQ_INTERVAL;
    logic [3:0] THRESHOLD_COUNTER_SOURCE;
    logic [7:0] REG_INDEX, REG_WDATA, REG_RDATA;
    logic BANK_SELECT, REG_WR, REG_RD, SOURCE_A_FLAG, SOURCE_B_FLAG, ENHANCED_IRQ_SCHEME;
    logic THRESHOLD_COUNT_INC, THRESHOLD_COUNT_CLEAR, THRESH_EVENT, IRQ_REQUEST;
    logic rd_d = 0, look = 0;
    logic [7:0] rd_q[$];
    logic [18:0] obs_q[$];
    int bad_count = 0, check_count = 0;

    iss_top i_iss_top (.*);
    iss_host i_iss_host (.ref_clk(REF_CLK), .bank_select(BANK_SELECT), .reg_index(REG_INDEX),
        .reg_wr(REG_WR), .reg_rd(REG_RD), .reg_wdata(REG_WDATA));

    // Clock at 20 MHz.
    initial forever #25 REF_CLK = ~REF_CLK;

    task automatic test_done();
        if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cmp_rd(input logic [7:0] a);
        logic [7:0] e;
        e = rd_q.pop_front();
        check_count++;
        if (a !== e) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, a, e);
        end
    endtask

    task automatic cmp_obs(input logic [18:0] a);
        logic [18:0] e;
        e = obs_q.pop_front();
        check_count++;
        if (a !== e) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, a, e);
        end
    endtask

    task automatic chk_rd(input logic b, input logic [7:0] i, input logic [7:0] e);
        rd_q.push_back(e);
        i_iss_host.acc(1'b0, b, i, 8'h00);
    endtask

    // Stimulus index that a selector code answers to; 99 means it never fires.
    function automatic int fm(input logic [3:0] c, input bit cnt);
        if (c[3]) return int'(c) - 2;
        case (c)
            4'h1: return cnt ? 4 : 99;
            4'h2: return cnt ? 5 : 0;
            4'h3: return 1;
            4'h4: return 2;
            4'h5: return 3;
            default: return 99;
        endcase
    endfunction

    // Results are judged one edge after they land, oldest note first.
    always @(posedge REF_CLK) begin
        if (rd_d) cmp_rd(REG_RDATA);
        if (look) cmp_obs({FIFO_IRQ_INTERVAL, ENHANCED_IRQ_SCHEME, THRESHOLD_COUNTER_SOURCE,
            IRQ_REQUEST, THRESHOLD_COUNT_CLEAR, THRESHOLD_COUNT_INC, THRESH_EVENT,
            SOURCE_B_FLAG, SOURCE_A_FLAG, STATUS_NIBBLE});
        rd_d <= REG_RD;
    end

    // Hang guard, well beyond the few thousand cycles the sequence needs.
    initial begin
        #1000000;
        bad_count++;
        test_done();
    end

    // Every code on both selectors against every event, with and without the status bank.
    initial begin
        logic [7:0] lo, hi, src;
        logic [3:0] pre;
        logic [4:0] r;
        logic a, b;
        int j;
        void'($urandom(73410));
        repeat (6) @(posedge REF_CLK);
        SRST <= 1'b0;
        chk_rd(1'b1, 8'h02, 8'h00);
        chk_rd(1'b1, 8'h04, 8'h00);
        chk_rd(1'b1, 8'h05, 8'h00);
        for (int be = 1; be >= 0; be--) for (int c = 0; c < 16; c++) begin
            lo = 8'($urandom) & 8'h0f;
            hi = {c[1], be[0], c[2], c[0], c[3:0]};
            src = {c[3:0] ^ 4'h1, c[3:0]};
            i_iss_host.acc(1'b1, 1'b1, 8'h04, lo);
            i_iss_host.acc(1'b1, 1'b1, 8'h05, hi);
            i_iss_host.acc(1'b1, 1'b1, 8'h02, src);
            i_iss_host.acc(1'b1, 1'b0, 8'h02, 8'hff);
            chk_rd(1'b0, 8'h02, 8'h00);
            chk_rd(1'b1, 8'h04, lo);
            chk_rd(1'b1, 8'h05, hi);
            chk_rd(1'b1, 8'h02, src);
            chk_rd(1'b1, 8'h03, 8'h00);
            ADC_CHANNEL <= 4'($urandom);
            for (int s = 0; s < 14; s++) begin
                j = s - 6;
                pre = 4'($urandom);
                r = 5'($urandom);
                if (s >= 6) pre[j >> 1] = j[0];
                @(posedge REF_CLK) DIGITAL_INPUT <= pre;
                @(posedge REF_CLK) CLEAR_FLAGS <= 1'b1;
                @(posedge REF_CLK);
                CLEAR_FLAGS <= 1'b0;
                {BLOCK_DONE, SAMPLE_DONE, TRIG_STOP, TRIG_START, FRAME_MAX, THRESH_REACHED}
                    <= (s < 6) ? 6'h01 << s : 6'h00;
                DIGITAL_INPUT <= pre ^ ((s >= 6) ? 4'h1 << (j >> 1) : 4'h0);
                {DMA_ENABLE, CLASSIC_SAMPLE_IRQ, CLASSIC_BURST_IRQ, DMA_IRQ, FIFO_IRQ} <= r;
                @(posedge REF_CLK);
                {BLOCK_DONE, SAMPLE_DONE, TRIG_STOP, TRIG_START, FRAME_MAX, THRESH_REACHED}
                    <= 6'h00;
                {DMA_ENABLE, CLASSIC_SAMPLE_IRQ, CLASSIC_BURST_IRQ, DMA_IRQ, FIFO_IRQ} <= 5'h00;
                a = be[0] && fm(c[3:0], 1'b0) == s;
                b = be[0] && fm(c[3:0] ^ 4'h1, 1'b0) == s;
                obs_q.push_back({lo[3:0], c[1], c[3:0],
                    ((r[3] | r[2]) & (!c[2] | r[4])) | r[1] | r[0], c[0] && s == 2,
                    fm(c[3:0], 1'b1) == s, s == 0, b, a,
                    be[0] ? {2'b00, b, a} : ADC_CHANNEL});
                look <= 1'b1;
                @(posedge REF_CLK) look <= 1'b0;
            end
        end
        repeat (3) @(posedge REF_CLK);
        test_done();
    end
endmodule

// >>> hw/iss_cfg.svh
/*
 * Register indices, field positions, reset values and block size for the
 * interrupt source select block.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef ISS_CFG_SVH
`define ISS_CFG_SVH

// Indexed register locations, reached with the bank select bit at one.
`define ISS_IDX_SRC_SEL   8'h02
`define ISS_IDX_CFG_LO    8'h04
`define ISS_IDX_CFG_HI    8'h05

// Reset values of the two registers.
`define ISS_SRC_SEL_RST   8'h00
`define ISS_CFG_RST       16'h0000

// Field positions in the configuration word.
`define ISS_CFG_EIS_BIT   15
`define ISS_CFG_SBE_BIT   14
`define ISS_CFG_CIB_BIT   13
`define ISS_CFG_SYNC_BIT  12
`define ISS_CFG_TSRC_HI   11
`define ISS_CFG_TSRC_LO   8
`define ISS_CFG_FIFO_HI   3
`define ISS_CFG_FIFO_LO   0

// Samples in one block.
`define ISS_BLOCK_SAMPLES 256

`endif

// >>> hw/iss_pkg.sv
/*
 * Types shared by the interrupt source select block.
 * Assumes the configuration header is on the include path.
 */
package iss_pkg;
    `include "iss_cfg.svh"

    // Event selector codes shared by source A and source B; the counter source differs at codes 1 and 2.
    typedef enum logic [3:0] {
        ISS_SEL_NONE     = 4'h0,
        ISS_SEL_RSVD     = 4'h1,
        ISS_SEL_THRESH   = 4'h2,
        ISS_SEL_FRAMEMAX = 4'h3,
        ISS_SEL_TRIG_ON  = 4'h4,
        ISS_SEL_TRIG_OFF = 4'h5
    } iss_sel_e;

    // Bus write phases; one-hot so each phase is a single flop.
    typedef enum logic [2:0] {
        ISS_BUS_IDLE = 3'b001,
        ISS_BUS_WR   = 3'b010,
        ISS_BUS_HOLD = 3'b100
    } iss_bus_e;
endpackage

// >>> hw/iss_top.sv
/*
 * Interrupt source select: routes acquisition and digital input events to the
 * source A and source B status flags while bit 14 is set, picks the threshold counter increment,
 * clears that counter at trigger start when asked, and gates classic
 * per-sample and per-burst interrupts.
 * Assumes a synchronous indexed register port on REF_CLK, event inputs that are
 * one-cycle pulses on REF_CLK, and digital inputs already synchronous.
 */
// Notes on behaviour
// - Source B selector in bits 7:4 sets flag B while bit 14 is set.
// - Source A selector in bits 3:0 sets flag A while bit 14 is set.
// - Codes 0..7 decode to none, counter, frame, trigger.
// - Codes 8..15 select input rising/falling edges.
// - Both registers reset to zero.
// - Bit 15 picks enhanced interrupt scheme.
// - Bit 14 puts source flags in status nibble.
// - Bit 13 blocks classic sample and burst interrupts.
// - DMA enable overrides the classic block.
// - DMA and FIFO interrupts ignore the block.
// - Bits 11:8 pick counter source; codes 1..3 sample, block, frame.
// - Codes 4,5 count trigger start/stop; 6,7 none.
// - Codes 8 upward count digital input edges.
// - Bit 12 clears counter at trigger start.
// - Registers at index 2, 4 and 5, bank one.
// - Bits 3:0 set FIFO interrupt interval.
// - Threshold reached yields event output.
`timescale 1ns/1ps
`include "iss_cfg.svh"

module iss_top (
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        SRST,
    // Indexed register port
    input  wire logic        BANK_SELECT,
    input  wire logic [7:0]  REG_INDEX,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [7:0]  REG_WDATA,
    output logic      [7:0]  REG_RDATA,
    // Event inputs, one-cycle pulses, and digital input levels
    input  wire logic        THRESH_REACHED,
    input  wire logic        FRAME_MAX,
    input  wire logic        SAMPLE_DONE,
    input  wire logic        BLOCK_DONE,
    input  wire logic        TRIG_START,
    input  wire logic        TRIG_STOP,
    input  wire logic [3:0]  DIGITAL_INPUT,
    // Classic interrupt sources and DMA mode
    input  wire logic        DMA_ENABLE,
    input  wire logic        CLASSIC_SAMPLE_IRQ,
    input  wire logic        CLASSIC_BURST_IRQ,
    input  wire logic        DMA_IRQ,
    input  wire logic        FIFO_IRQ,
    // Status and flag clearing
    input  wire logic [3:0]  ADC_CHANNEL,
    input  wire logic        CLEAR_FLAGS,
    output logic      [3:0]  STATUS_NIBBLE,
    output logic             SOURCE_A_FLAG,
    output logic             SOURCE_B_FLAG,
    // Configuration outputs
    output logic             ENHANCED_IRQ_SCHEME,
    output logic      [3:0]  FIFO_IRQ_INTERVAL,
    output logic      [3:0]  THRESHOLD_COUNTER_SOURCE,
    // Threshold counter controls
    output logic             THRESHOLD_COUNT_INC,
    output logic             THRESHOLD_COUNT_CLEAR,
    output logic             THRESH_EVENT,
    // Gated interrupt request
    output logic             IRQ_REQUEST
);
    import iss_pkg::*;

    logic [7:0]  src_sel_q;
    logic [7:0]  src_sel_d;
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic [3:0]  din_q;
    logic        flag_a_q;
    logic        flag_b_q;
    logic [7:0]  rdata_q;
    iss_bus_e    bus_q;
    iss_bus_e    bus_d;
    logic [3:0]  status_q;
    logic        eis_q;
    logic [3:0]  fifo_q;
    logic [3:0]  tsrc_q;
    logic        inc_q;
    logic        clr_q;
    logic        thr_q;
    logic        irq_q;

    // Register decode; the set is only visible with the bank select high.
    wire         hit_sel  = BANK_SELECT && (REG_INDEX == `ISS_IDX_SRC_SEL);
    wire         hit_lo   = BANK_SELECT && (REG_INDEX == `ISS_IDX_CFG_LO);
    wire         hit_hi   = BANK_SELECT && (REG_INDEX == `ISS_IDX_CFG_HI);
    wire         wr_take  = REG_WR && (bus_q == ISS_BUS_IDLE);

    // Configuration fields.
    wire [3:0]   source_a_select          = src_sel_q[3:0];
    wire [3:0]   source_b_select          = src_sel_q[7:4];
    wire         enhanced_irq_scheme      = cfg_q[`ISS_CFG_EIS_BIT];
    wire         status_bank_enable       = cfg_q[`ISS_CFG_SBE_BIT];
    wire         classic_irq_block        = cfg_q[`ISS_CFG_CIB_BIT];
    wire         threshold_trigger_sync   = cfg_q[`ISS_CFG_SYNC_BIT];
    wire [3:0]   threshold_counter_source = cfg_q[`ISS_CFG_TSRC_HI:`ISS_CFG_TSRC_LO];
    wire [3:0]   fifo_irq_interval        = cfg_q[`ISS_CFG_FIFO_HI:`ISS_CFG_FIFO_LO];

    // Edge pulses from registered levels: each edge gives exactly one pulse.
    wire [3:0]   din_rise = DIGITAL_INPUT & ~din_q;
    wire [3:0]   din_fall = ~DIGITAL_INPUT & din_q;

    // Event vector indexed by selector code. Code 1 is reserved and never fires.
    wire [15:0]  sel_events = {din_fall[3], din_rise[3], din_fall[2], din_rise[2],
                               din_fall[1], din_rise[1], din_fall[0], din_rise[0],
                               2'b00, TRIG_STOP, TRIG_START, FRAME_MAX,
                               THRESH_REACHED, 2'b00};
    wire         ev_a = sel_events[source_a_select];
    wire         ev_b = sel_events[source_b_select];

    // Counter increment vector; codes 1 and 2 differ from the flag selectors.
    wire [15:0]  cnt_events = {din_fall[3], din_rise[3], din_fall[2], din_rise[2],
                               din_fall[1], din_rise[1], din_fall[0], din_rise[0],
                               2'b00, TRIG_STOP, TRIG_START,
                               FRAME_MAX, BLOCK_DONE, SAMPLE_DONE, 1'b0};
    wire         cnt_inc = cnt_events[threshold_counter_source];

    // Classic gating: the block bit only bites while DMA mode is off.
    wire         classic_ok  = !classic_irq_block || DMA_ENABLE;
    wire         irq_d       = (classic_ok && (CLASSIC_SAMPLE_IRQ || CLASSIC_BURST_IRQ))
                               || DMA_IRQ || FIFO_IRQ;

    // Flag update: a new event wins over a clear in the same cycle.
    wire         flag_a_d = ev_a || (flag_a_q && !CLEAR_FLAGS);
    wire         flag_b_d = ev_b || (flag_b_q && !CLEAR_FLAGS);

    // Status nibble: channel by default, source flags when the bank is on.
    wire [3:0]   status_d = status_bank_enable ? {2'b00, flag_b_d, flag_a_d}
                                               : ADC_CHANNEL;

    // Read mux; unmapped indices read zero.
    wire [7:0]   rdata_d = hit_sel ? src_sel_q   :
                           hit_lo  ? cfg_q[7:0]  :
                           hit_hi  ? cfg_q[15:8] : 8'h00;

    // Register writes. A write is taken once, then the port must drop REG_WR.
    assign src_sel_d = (wr_take && hit_sel) ? REG_WDATA : src_sel_q;
    assign cfg_d     = {(wr_take && hit_hi) ? REG_WDATA : cfg_q[15:8],
                        (wr_take && hit_lo) ? REG_WDATA : cfg_q[7:0]};

    // Bus phase: idle takes a write, wait for strobe release before the next.
    always_comb begin
        case (bus_q)
            ISS_BUS_IDLE: bus_d = REG_WR ? ISS_BUS_WR : ISS_BUS_IDLE;
            ISS_BUS_WR:   bus_d = REG_WR ? ISS_BUS_HOLD : ISS_BUS_IDLE;
            ISS_BUS_HOLD: bus_d = REG_WR ? ISS_BUS_HOLD : ISS_BUS_IDLE;
            default:      bus_d = ISS_BUS_IDLE;
        endcase
    end

    // Host registers and bus state.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            src_sel_q <= `ISS_SRC_SEL_RST;
            cfg_q     <= `ISS_CFG_RST;
            bus_q     <= ISS_BUS_IDLE;
            rdata_q   <= 8'h00;
        end else begin
            src_sel_q <= src_sel_d;
            cfg_q     <= cfg_d;
            bus_q     <= bus_d;
            rdata_q   <= REG_RD ? rdata_d : rdata_q;
        end
    end

    // Event side: flags, input history and every registered output except REG_RDATA.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            din_q    <= 4'h0;
            flag_a_q <= 1'b0;
            flag_b_q <= 1'b0;
            status_q <= 4'h0;
            eis_q    <= 1'b0;
            fifo_q   <= 4'h0;
            tsrc_q   <= 4'h0;
            inc_q    <= 1'b0;
            clr_q    <= 1'b0;
            thr_q    <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            din_q    <= DIGITAL_INPUT;
            flag_a_q <= flag_a_d && status_bank_enable;
            flag_b_q <= flag_b_d && status_bank_enable;
            status_q <= status_d;
            eis_q    <= enhanced_irq_scheme;
            fifo_q   <= fifo_irq_interval;
            tsrc_q   <= threshold_counter_source;
            inc_q    <= cnt_inc;
            clr_q    <= threshold_trigger_sync && TRIG_START;
            thr_q    <= THRESH_REACHED;
            irq_q    <= irq_d;
        end
    end

    // Outputs, each straight from a flop.
    assign REG_RDATA                = rdata_q;
    assign STATUS_NIBBLE            = status_q;
    assign SOURCE_A_FLAG            = flag_a_q;
    assign SOURCE_B_FLAG            = flag_b_q;
    assign ENHANCED_IRQ_SCHEME      = eis_q;
    assign FIFO_IRQ_INTERVAL        = fifo_q;
    assign THRESHOLD_COUNTER_SOURCE = tsrc_q;
    assign THRESHOLD_COUNT_INC      = inc_q;
    assign THRESHOLD_COUNT_CLEAR    = clr_q;
    assign THRESH_EVENT             = thr_q;
    assign IRQ_REQUEST              = irq_q;

endmodule
